// ---- logic/exec_params.svh ----
// constants for the arithmetic and bit-operation execution unit
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
`define DATA_W 8
`define ADDR_W 7
`define BIT_W 3
`define FILE_DEPTH 128
`define ACC_RESET 8'h00
`define NIBBLE_MSB 3
`define PORT_ADDR_A 7'h05
`define PORT_ADDR_B 7'h07
`endif

// ---- logic/exec_pkg.sv ----
// types shared by the execution unit
package exec_pkg;
    typedef enum logic [2:0] {
        add_literal_op,
        add_acc_to_file_op,
        and_literal_op,
        and_acc_file_op,
        clear_bit_op,
        set_bit_op,
        skip_if_bit_one_op,
        skip_if_bit_zero_op
    } op_e;

    typedef struct packed {
        logic valid;
        op_e op;
        logic [6:0] addr;
        logic dest;
        logic [2:0] bit_idx;
        logic [7:0] literal;
    } instr_s;

    typedef struct packed {
        logic carry;
        logic nibble_overflow_flag;
        logic zero;
    } flags_s;
endpackage

// ---- logic/mcu_arith_bitop_exec.sv ----
// execution unit for add, and, bit set/clear and bit-test-skip
`timescale 1ns/1ns
`default_nettype none
`include "exec_params.svh"
module mcu_arith_bitop_exec
    import exec_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // instruction from the sequencer
    input wire instr_s instr,
    // port pins read back on read-modify-write
    input wire logic [7:0] port_a_pins,
    input wire logic [7:0] port_b_pins,
    // state seen by the core
    output logic [7:0] acc,
    output flags_s flags,
    output logic squash_next,
    // port latch outputs
    output logic [7:0] port_a_latch,
    output logic [7:0] port_b_latch
);
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic [7:0] pa_meta_reg, pa_sync_reg, pb_meta_reg, pb_sync_reg;
    logic [7:0] file_mem [0:`FILE_DEPTH-1];
    logic [7:0] acc_reg;
    flags_s flags_reg;
    logic skip_reg;
    logic [7:0] operand;
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] result;
    logic write_file;
    logic write_acc;
    logic test_bit;

    function automatic logic is_port(input logic [6:0] a);
        is_port = (a == `PORT_ADDR_A) || (a == `PORT_ADDR_B);
    endfunction

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // pins are asynchronous, two stages before use
    always_ff @(posedge clock)
    begin
        pa_meta_reg <= port_a_pins;
        pa_sync_reg <= pa_meta_reg;
        pb_meta_reg <= port_b_pins;
        pb_sync_reg <= pb_meta_reg;
    end

    wire logic active = instr.valid && !skip_reg;

    // operand selection and result
    always_comb
    begin
        if (instr.addr == `PORT_ADDR_A)
            operand = pa_sync_reg;
        else if (instr.addr == `PORT_ADDR_B)
            operand = pb_sync_reg;
        else
            operand = file_mem[instr.addr];
        if (instr.op == add_literal_op || instr.op == and_literal_op)
            operand = instr.literal;
        sum = {1'b0, acc_reg} + {1'b0, operand};
        low_sum = {1'b0, acc_reg[3:0]} + {1'b0, operand[3:0]};
        test_bit = operand[instr.bit_idx];
        case (instr.op)
            add_literal_op, add_acc_to_file_op: result = sum[7:0];
            and_literal_op, and_acc_file_op: result = acc_reg & operand;
            clear_bit_op: result = operand & ~(8'h01 << instr.bit_idx);
            set_bit_op: result = operand | (8'h01 << instr.bit_idx);
            default: result = operand;
        endcase
        write_acc = 1'b0;
        write_file = 1'b0;
        case (instr.op)
            add_literal_op, and_literal_op: write_acc = active;
            add_acc_to_file_op, and_acc_file_op:
            begin
                write_acc = active && !instr.dest;
                write_file = active && instr.dest;
            end
            clear_bit_op, set_bit_op: write_file = active;
            default: ;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (write_file && !is_port(instr.addr))
            file_mem[instr.addr] <= result;
    end

    always_ff @(posedge clock or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            port_a_latch <= 8'h00;
            port_b_latch <= 8'h00;
        end
        else if (write_file && instr.addr == `PORT_ADDR_A)
            port_a_latch <= result;
        else if (write_file && instr.addr == `PORT_ADDR_B)
            port_b_latch <= result;
    end

    always_ff @(posedge clock or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            acc_reg <= `ACC_RESET;
        else if (write_acc)
            acc_reg <= result;
    end

    // flags: only add and and touch them
    always_ff @(posedge clock or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            flags_reg <= '0;
        else if (active)
        begin
            case (instr.op)
                add_literal_op, add_acc_to_file_op:
                begin
                    flags_reg.carry <= sum[8];
                    flags_reg.nibble_overflow_flag <= low_sum[4];
                    flags_reg.zero <= (sum[7:0] == 8'h00);
                end
                and_literal_op, and_acc_file_op: flags_reg.zero <= (result == 8'h00);
                default: ;
            endcase
        end
    end

    // a squashed slot cannot itself skip, so skips never chain
    always_ff @(posedge clock or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            skip_reg <= 1'b0;
        else
            skip_reg <= active && ((instr.op == skip_if_bit_one_op && test_bit)
                || (instr.op == skip_if_bit_zero_op && !test_bit));
    end

    assign acc = acc_reg;
    assign flags = flags_reg;
    assign squash_next = skip_reg;

    property p_skip_one;
        @(posedge clock) disable iff (!rst_sync_reg)
        active && instr.op == skip_if_bit_one_op |-> ##1 squash_next == $past(test_bit);
    endproperty
    a_skip_one: assert property (p_skip_one) else $error("skip if one wrong");

    property p_skip_zero;
        @(posedge clock) disable iff (!rst_sync_reg)
        active && instr.op == skip_if_bit_zero_op |-> ##1 squash_next == !$past(test_bit);
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("skip if zero wrong");

    property p_no_skip_flags;
        @(posedge clock) disable iff (!rst_sync_reg)
        active && (instr.op inside {skip_if_bit_one_op, skip_if_bit_zero_op, clear_bit_op, set_bit_op})
        |=> $stable(flags);
    endproperty
    a_no_skip_flags: assert property (p_no_skip_flags) else $error("flags changed");

    property p_add_lit;
        @(posedge clock) disable iff (!rst_sync_reg)
        active && instr.op == add_literal_op |=> acc == $past(acc_reg + instr.literal);
    endproperty
    a_add_lit: assert property (p_add_lit) else $error("add literal wrong");

    // zero follows the 8-bit sum whichever destination took it
    property p_zero_add;
        @(posedge clock) disable iff (!rst_sync_reg)
        active && instr.op == add_acc_to_file_op |=> flags.zero == ($past(acc_reg + operand) == 8'h00);
    endproperty
    a_zero_add: assert property (p_zero_add) else $error("zero flag after add wrong");

    property p_and_lit;
        @(posedge clock) disable iff (!rst_sync_reg)
        active && instr.op == and_literal_op |=> acc == $past(acc_reg & instr.literal)
            && flags.carry == $past(flags.carry) && flags.zero == (acc == 8'h00);
    endproperty
    a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

    property p_dest_file;
        @(posedge clock) disable iff (!rst_sync_reg)
        active && instr.op inside {add_acc_to_file_op, and_acc_file_op} && instr.dest |=> $stable(acc);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("acc written for file dest");

    property p_carry;
        @(posedge clock) disable iff (!rst_sync_reg)
        active && instr.op == add_acc_to_file_op |=> flags.carry == $past(sum[8])
            && flags.nibble_overflow_flag == $past(low_sum[4]);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flags wrong");

    property p_squash_once;
        @(posedge clock) disable iff (!rst_sync_reg)
        squash_next |=> !squash_next;
    endproperty
    a_squash_once: assert property (p_squash_once) else $error("skip chained");

    c_skip: cover property (@(posedge clock) disable iff (!rst_sync_reg) squash_next);
    c_carry: cover property (@(posedge clock) disable iff (!rst_sync_reg) flags.carry);
    c_port: cover property (@(posedge clock) disable iff (!rst_sync_reg) write_file && is_port(instr.addr));
endmodule
`default_nettype wire

// ---- verif/tb_mcu_arith_bitop_exec.sv ----
// self-checking testbench for the arithmetic and bit-operation execution unit
`timescale 1ns/1ns
`default_nettype none
module tb_mcu_arith_bitop_exec import exec_pkg::*;;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    instr_s instr = '0;
    logic [7:0] pa = 8'h00;
    logic [7:0] pb = 8'h00;
    logic [7:0] acc, la, lb;
    flags_s flags;
    logic squash_next;
    int err_count = 0;
    int comparisons = 0;

    mcu_arith_bitop_exec u_mcu_arith_bitop_exec (.clock(clock), .nrst(nrst), .instr(instr), .port_a_pins(pa),
        .port_b_pins(pb), .acc(acc), .flags(flags), .squash_next(squash_next), .port_a_latch(la), .port_b_latch(lb));

    always #25 clock = ~clock;

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flags(input flags_s got, input flags_s exp);
        chk_byte({5'h00, got}, {5'h00, exp});
    endtask

    // a tb-side model of the add flags, never the design's own logic
    function automatic flags_s add_flags(input logic [7:0] x, input logic [7:0] y);
        logic [8:0] s;
        s = x + y;
        return '{s[8], ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0f, s[7:0] == 8'h00};
    endfunction

    // caller stands at a falling edge; results are settled on return
    task automatic issue(input op_e o, input logic [6:0] a, input logic d, input logic [2:0] b, input logic [7:0] k);
        instr = '{1'b1, o, a, d, b, k};
        @(negedge clock);
    endtask

    // pins go through a two-flop synchroniser, so give them three cycles
    task automatic idle(input int n);
        instr.valid = 1'b0;
        repeat (n) @(negedge clock);
    endtask

    task automatic t_add_literal();
        issue(add_literal_op, 7'h00, 1'b0, 3'h0, 8'h0f);
        chk_byte(acc, 8'h0f);
        issue(add_literal_op, 7'h00, 1'b0, 3'h0, 8'h01);
        chk_flags(flags, 3'b010);
        issue(add_literal_op, 7'h00, 1'b0, 3'h0, 8'hf0);
        chk_byte(acc, 8'h00);
        chk_flags(flags, 3'b101);
    endtask

    task automatic t_and_literal();
        issue(add_literal_op, 7'h00, 1'b0, 3'h0, 8'hf8);
        issue(add_literal_op, 7'h00, 1'b0, 3'h0, 8'h18);
        chk_flags(flags, 3'b110);
        issue(and_literal_op, 7'h00, 1'b0, 3'h0, 8'h30);
        chk_byte(acc, 8'h10);
        chk_flags(flags, 3'b110);
        issue(and_literal_op, 7'h00, 1'b0, 3'h0, 8'h01);
        chk_flags(flags, 3'b111);
    endtask

    task automatic t_file_ops();
        pa = 8'h3c;
        idle(3);
        issue(add_acc_to_file_op, 7'h05, 1'b0, 3'h0, 8'h00);
        chk_byte(acc, 8'h3c);
        chk_byte(la, 8'h00);
        issue(add_acc_to_file_op, 7'h05, 1'b1, 3'h0, 8'h00);
        chk_byte(la, 8'h78);
        chk_flags(flags, 3'b010);
        issue(and_acc_file_op, 7'h05, 1'b1, 3'h0, 8'h00);
        chk_byte(la, 8'h3c);
        chk_byte(acc, 8'h3c);
        issue(and_acc_file_op, 7'h07, 1'b0, 3'h0, 8'h00);
        chk_byte(acc, 8'h00);
        chk_flags(flags, 3'b011);
        // zeroing an unreset location first: zero AND unknown is zero
        issue(and_acc_file_op, 7'h20, 1'b1, 3'h0, 8'h00);
        issue(add_literal_op, 7'h00, 1'b0, 3'h0, 8'h81);
        issue(add_acc_to_file_op, 7'h20, 1'b1, 3'h0, 8'h00);
        issue(add_acc_to_file_op, 7'h20, 1'b0, 3'h0, 8'h00);
        chk_byte(acc, 8'h02);
        chk_flags(flags, 3'b100);
    endtask

    task automatic t_bit_ops();
        issue(set_bit_op, 7'h05, 1'b0, 3'h7, 8'h00);
        chk_byte(la, 8'hbc);
        issue(clear_bit_op, 7'h05, 1'b0, 3'h2, 8'h00);
        chk_byte(la, 8'h38);
        for (int i = 0; i < 8; i++)
        begin
            issue(set_bit_op, 7'h07, 1'b0, i[2:0], 8'h00);
            chk_byte(lb, 8'h01 << i);
        end
        pb = 8'hff;
        idle(3);
        for (int i = 0; i < 8; i++)
        begin
            issue(clear_bit_op, 7'h07, 1'b0, i[2:0], 8'h00);
            chk_byte(lb, ~(8'h01 << i));
        end
        chk_flags(flags, 3'b100);
    endtask

    task automatic t_skip();
        logic [7:0] a;
        flags_s f;
        logic taken;
        a = 8'h02;
        f = 3'b100;
        for (int j = 0; j < 16; j++)
        begin
            taken = (j < 8) ? pa[j % 8] : !pa[j % 8];
            issue((j < 8) ? skip_if_bit_one_op : skip_if_bit_zero_op, 7'h05, 1'b0, j[2:0], 8'h00);
            chk_byte({7'h00, squash_next}, {7'h00, taken});
            chk_flags(flags, f);
            issue(add_literal_op, 7'h00, 1'b0, 3'h0, 8'h01);
            if (!taken)
            begin
                f = add_flags(a, 8'h01);
                a = a + 8'h01;
            end
            chk_byte(acc, a);
            chk_byte({7'h00, squash_next}, 8'h00);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(negedge clock);
        nrst = 1'b1;
        idle(3);
        chk_byte(acc, 8'h00);
        chk_flags(flags, 3'b000);
        chk_byte(la, 8'h00);
        chk_byte(lb, 8'h00);
        chk_byte({7'h00, squash_next}, 8'h00);
        t_add_literal();
        t_and_literal();
        t_file_ops();
        t_bit_ops();
        t_skip();
        idle(1);
        conclude();
    end

    initial
    begin
        repeat (2000) @(posedge clock);
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire
